// >>> src/wdr_pkg.sv
// Package: register map, field layouts, codes and timing for the watchdog and reset control
package wdr_pkg;
    // Register byte addresses (offsets chosen for this block)
    localparam logic [3:0] ADDR_WDT_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RST_FLAGS = 4'h4;
    localparam logic [3:0] ADDR_PIN_CFG = 4'h8;
    localparam logic [3:0] ADDR_CMD = 4'hc;
    // Watchdog control layout and codes
    localparam logic [7:0] WDT_CTRL_POR = 8'h53;
    localparam logic [4:0] KEY_DISABLE = 5'h15;
    localparam logic [4:0] KEY_ENABLE = 5'h0a;
    localparam int KEY_LSB = 3;
    // Reset pin configuration codes
    localparam logic [7:0] PIN_CFG_IO = 8'h55;
    localparam logic [7:0] PIN_CFG_RESET = 8'haa;
    // Reset flag bit positions
    localparam int FLAG_WDT_KEY = 0;
    localparam int FLAG_LV_KEY = 1;
    localparam int FLAG_LV_EVENT = 2;
    localparam int FLAG_PIN_CFG = 3;
    localparam int FLAG_TIMEOUT = 4;
    localparam int FLAG_PDOWN = 5;
    // Command register bits
    localparam int CMD_CLEAR = 0;
    localparam int CMD_HALT = 1;
    // Largest divider exponent (select code 7)
    localparam int DIV_EXP_MAX = 18;
    // Timing: software reset delay and release delay in low-speed clock cycles
    localparam int SW_RESET_CYCLES = 4;
    localparam int RELEASE_CYCLES = 16;
    localparam int CNT_W = 19;
    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Reset outputs grouped
    typedef struct packed {
        logic full_reset;
        logic pc_sp_reset;
        logic inhibit;
        logic ports_preset;
    } wdr_reset_t;
endpackage : wdr_pkg

// >>> src/wdr_top.sv
// Watchdog timer with keyed enable, reset-pin configuration and reset cause flags
// Function
// - Key 10101 disables, 01010 enables watchdog
// - Any other key: full reset after delay
// - Power-on loads key 01010, watchdog enabled
// - Three-bit select sets divider 2^8 to 2^18
// - Illegal key sets bit 0, software-zero clears
// - Normal overflow: full reset, time-out flag set
// - Sleep overflow: flag, reset only PC/SP
// - Key fault, clear, halt, pin clear counter
// - Power-on reset starts program at zero
// - Power-on presets ports to all ones
// - Pin is reset only when configured so
// - After pin release, wait delay, inhibit
// - Pin low resets program counter to zero
// - Pin config 55 I/O, AA reset, else reset
// - Power-on loads pin config 01010101
// - Counter clocked by low-speed RC clock
// - Illegal pin config sets bit 3 flag
`timescale 1ns/1ps
module wdr_top #(
    parameter int SW_DELAY = wdr_pkg::SW_RESET_CYCLES,   // Software reset delay
    parameter int REL_DELAY = wdr_pkg::RELEASE_CYCLES     // Pin release delay
) (
    input wire logic SYS_CLK,          // Low-speed RC clock
    input wire logic RST,              // Power-on reset, async high
    input wire logic CLK_EN,           // Freezes all state while low
    input wire logic CLR_INSTR,        // Clear-watchdog instruction pulse
    input wire logic HALT_INSTR,       // Halt instruction pulse
    input wire logic LOW_POWER,        // Sleep or idle mode level
    input wire logic EXT_RESET_N_IN,   // Shared pin input level
    output logic PIN_IO_IN,            // Pin level for I/O use
    output logic PIN_IS_RESET,         // Pin serves as reset
    output wdr_pkg::wdr_reset_t RESETS, // Reset outputs
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [7:0] wdt_ctrl;          // Key and divider select
    logic [7:0] pin_cfg;           // Reset pin configuration
    logic [5:0] flags;             // Reset cause flags
    logic [wdr_pkg::CNT_W-1:0] cnt; // Watchdog counter
    logic pin_s1, pin_s2;          // Pin synchroniser
    logic [7:0] sw_cnt;            // Software reset delay counter
    logic [7:0] rel_cnt;           // Release delay counter
    logic [1:0] por_seen;          // Power-on preset pulse shaping
    logic aw_hold, w_hold;         // Captured write halves
    logic [3:0] aw_addr;           // Captured write address
    logic [31:0] w_data;           // Captured write data
    logic [3:0] w_strb;            // Captured strobes
    logic do_write;                // Write commits this cycle
    logic wr_ok;                   // Write address mapped
    logic [4:0] key;               // Enable key field
    logic [2:0] sel;               // Divider select
    logic key_bad, cfg_bad;        // Illegal codes
    logic wdt_on;                  // Watchdog enabled
    logic pin_low;                 // Configured pin asserted
    logic clr_any;                 // Any counter clear
    logic overflow;                // Counter reached limit
    logic [4:0] div_exp;           // Selected exponent
    logic pending;                 // Software reset pending
    logic wr_clear, wr_halt;       // Command pulses from bus

    assign key = wdt_ctrl[7:wdr_pkg::KEY_LSB];
    assign sel = wdt_ctrl[wdr_pkg::KEY_LSB-1:0];
    assign key_bad = (key != wdr_pkg::KEY_ENABLE) && (key != wdr_pkg::KEY_DISABLE);
    assign wdt_on = (key == wdr_pkg::KEY_ENABLE);
    assign cfg_bad = (pin_cfg != wdr_pkg::PIN_CFG_IO) && (pin_cfg != wdr_pkg::PIN_CFG_RESET);
    assign PIN_IS_RESET = (pin_cfg == wdr_pkg::PIN_CFG_RESET);
    assign pin_low = PIN_IS_RESET && !pin_s2;
    assign PIN_IO_IN = pin_s2;
    assign pending = key_bad || cfg_bad;

    ////////////////////////////////////////////////////////////////////////////
    // Divider select decode
    always_comb begin
        unique case (sel)
            3'h0: div_exp = 5'h08;
            3'h1: div_exp = 5'h0a;
            3'h2: div_exp = 5'h0c;
            3'h3: div_exp = 5'h0e;
            3'h4: div_exp = 5'h0f;
            3'h5: div_exp = 5'h10;
            3'h6: div_exp = 5'h11;
            default: div_exp = 5'h12;
        endcase
    end

    // Overflow when the counter reaches 2^exp minus one
    assign overflow = wdt_on && (cnt == ((19'h00001 << div_exp) - 19'h00001));
    assign clr_any = key_bad || CLR_INSTR || wr_clear || HALT_INSTR || wr_halt || pin_low;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            pin_s1 <= 1'b1;
            pin_s2 <= 1'b1;
        end else if (CLK_EN) begin
            pin_s1 <= EXT_RESET_N_IN;
            pin_s2 <= pin_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog counter on the low-speed clock
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            cnt <= '0;
        end else if (CLK_EN) begin
            if (!wdt_on || clr_any || overflow) begin
                cnt <= '0;
            end else begin
                cnt <= cnt + 19'h00001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Software reset delay: counts while an illegal code stands
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            sw_cnt <= '0;
        end else if (CLK_EN) begin
            if (!pending || RESETS.full_reset) begin
                sw_cnt <= '0;
            end else if (sw_cnt < 8'(SW_DELAY)) begin
                sw_cnt <= sw_cnt + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset outputs and release delay
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            RESETS <= '{full_reset: 1'b1, pc_sp_reset: 1'b1, inhibit: 1'b1, ports_preset: 1'b1};
            rel_cnt <= '0;
            por_seen <= '0;
        end else if (CLK_EN) begin
            por_seen <= {por_seen[0], 1'b1};
            RESETS.ports_preset <= !por_seen[1];
            RESETS.full_reset <= pin_low || (pending && sw_cnt == 8'(SW_DELAY))
                || (overflow && !LOW_POWER);
            RESETS.pc_sp_reset <= pin_low || (overflow && LOW_POWER) || (pending && sw_cnt == 8'(SW_DELAY))
                || (overflow && !LOW_POWER);
            if (pin_low) begin
                rel_cnt <= '0;
                RESETS.inhibit <= 1'b1;
            end else if (rel_cnt < 8'(REL_DELAY)) begin
                rel_cnt <= rel_cnt + 8'h01;
                RESETS.inhibit <= 1'b1;
            end else begin
                RESETS.inhibit <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel
    assign S_AXI_AWREADY = !aw_hold && !S_AXI_BVALID;
    assign S_AXI_WREADY = !w_hold && !S_AXI_BVALID;
    assign do_write = aw_hold && w_hold && !S_AXI_BVALID;
    assign wr_ok = (aw_addr == wdr_pkg::ADDR_WDT_CTRL) || (aw_addr == wdr_pkg::ADDR_RST_FLAGS)
        || (aw_addr == wdr_pkg::ADDR_PIN_CFG) || (aw_addr == wdr_pkg::ADDR_CMD);
    assign wr_clear = do_write && aw_addr == wdr_pkg::ADDR_CMD && w_strb[0] && w_data[wdr_pkg::CMD_CLEAR];
    assign wr_halt = do_write && aw_addr == wdr_pkg::ADDR_CMD && w_strb[0] && w_data[wdr_pkg::CMD_HALT];

    // Capture address and data in either order, then answer
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= wdr_pkg::RESP_OKAY;
        end else if (CLK_EN) begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
                aw_hold <= 1'b1;
                aw_addr <= {S_AXI_AWADDR[3:2], 2'b00};
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
                w_hold <= 1'b1;
                w_data <= S_AXI_WDATA;
                w_strb <= S_AXI_WSTRB;
            end
            if (do_write) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                S_AXI_BRESP <= wr_ok ? wdr_pkg::RESP_OKAY : wdr_pkg::RESP_SLVERR;
            end else if (S_AXI_BVALID && S_AXI_BREADY) begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers, reloaded by every full reset
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            wdt_ctrl <= wdr_pkg::WDT_CTRL_POR;
            pin_cfg <= wdr_pkg::PIN_CFG_IO;
        end else if (CLK_EN) begin
            if (RESETS.full_reset) begin
                wdt_ctrl <= wdr_pkg::WDT_CTRL_POR;
                pin_cfg <= wdr_pkg::PIN_CFG_IO;
            end else if (do_write && w_strb[0]) begin
                if (aw_addr == wdr_pkg::ADDR_WDT_CTRL) begin
                    wdt_ctrl <= w_data[7:0];
                end
                if (aw_addr == wdr_pkg::ADDR_PIN_CFG) begin
                    pin_cfg <= w_data[7:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reset cause flags: hardware set wins over software clear
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            flags <= '0;
        end else if (CLK_EN) begin
            if (do_write && w_strb[0] && aw_addr == wdr_pkg::ADDR_RST_FLAGS) begin
                for (int i = 0; i < $bits(flags); i++) begin
                    if (!w_data[i]) flags[i] <= 1'b0;
                end
            end
            // Clears come first so that a set in the same cycle wins
            if (CLR_INSTR || wr_clear) flags[wdr_pkg::FLAG_PDOWN] <= 1'b0;
            if (HALT_INSTR || wr_halt) begin
                flags[wdr_pkg::FLAG_PDOWN] <= 1'b1;
                flags[wdr_pkg::FLAG_TIMEOUT] <= 1'b0;
            end
            if (key_bad && sw_cnt == 8'(SW_DELAY)) flags[wdr_pkg::FLAG_WDT_KEY] <= 1'b1;
            if (cfg_bad && sw_cnt == 8'(SW_DELAY)) flags[wdr_pkg::FLAG_PIN_CFG] <= 1'b1;
            if (overflow) flags[wdr_pkg::FLAG_TIMEOUT] <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel
    assign S_AXI_ARREADY = !S_AXI_RVALID;
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= '0;
            S_AXI_RRESP <= wdr_pkg::RESP_OKAY;
        end else if (CLK_EN) begin
            if (S_AXI_ARVALID && S_AXI_ARREADY) begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= wdr_pkg::RESP_OKAY;
                unique case ({S_AXI_ARADDR[3:2], 2'b00})
                    wdr_pkg::ADDR_WDT_CTRL: S_AXI_RDATA <= {24'h000000, wdt_ctrl};
                    wdr_pkg::ADDR_RST_FLAGS: S_AXI_RDATA <= {26'h0, flags};
                    wdr_pkg::ADDR_PIN_CFG: S_AXI_RDATA <= {24'h000000, pin_cfg};
                    wdr_pkg::ADDR_CMD: S_AXI_RDATA <= '0;
                    default: begin
                        S_AXI_RDATA <= '0;
                        S_AXI_RRESP <= wdr_pkg::RESP_SLVERR;
                    end
                endcase
            end else if (S_AXI_RVALID && S_AXI_RREADY) begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Disabled watchdog holds its counter at zero
    chk_disabled_idle: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && !wdt_on) |=> (cnt == '0)) else $error("Counter moved while disabled");

    // Enabled watchdog steps by one per clock
    chk_key_enable: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && wdt_on && !clr_any && !overflow) |=> (cnt == $past(cnt) + 19'h00001))
        else $error("Enabled counter did not step");

    // Illegal code ends in a full reset
    chk_sw_reset: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && pending && sw_cnt == 8'(SW_DELAY) && !RESETS.full_reset) |=> RESETS.full_reset)
        else $error("Software reset missing");

    // Fault flags follow the software reset
    chk_key_flag: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && key_bad && sw_cnt == 8'(SW_DELAY)) |=> flags[wdr_pkg::FLAG_WDT_KEY])
        else $error("Key fault flag not set");
    chk_cfg_flag: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && cfg_bad && sw_cnt == 8'(SW_DELAY)) |=> flags[wdr_pkg::FLAG_PIN_CFG])
        else $error("Pin fault flag not set");

    // Overflow: full reset when running, program counter and stack only when asleep
    chk_ovf_normal: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && overflow && !LOW_POWER) |=> (RESETS.full_reset && flags[wdr_pkg::FLAG_TIMEOUT]))
        else $error("Overflow reset missing");
    chk_ovf_sleep: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && overflow && LOW_POWER && !pin_low && !pending) |=> (RESETS.pc_sp_reset && !RESETS.full_reset))
        else $error("Sleep overflow wrong");

    // Instruction and bus command clears
    chk_clear_cnt: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && (CLR_INSTR || HALT_INSTR)) |=> (cnt == '0)) else $error("Clear did not clear");
    chk_cmd_clear: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && (wr_clear || wr_halt)) |=> (cnt == '0)) else $error("Command did not clear");

    // Pin resets only when configured so, then holds operation off
    chk_pin_io: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && !PIN_IS_RESET && !pending && !overflow) |=> !RESETS.full_reset)
        else $error("Pin reset while I/O");
    chk_pin_inhibit: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && pin_low) |=> (RESETS.inhibit && RESETS.pc_sp_reset)) else $error("Pin reset not held");
    chk_inhibit_end: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && !pin_low && rel_cnt == 8'(REL_DELAY)) |=> !RESETS.inhibit) else $error("Inhibit not released");

    // Power-on preset and full-reset reload
    chk_ports_preset: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && por_seen[1]) |=> !RESETS.ports_preset) else $error("Port preset stuck");
    chk_ctrl_reload: assert property (@(posedge SYS_CLK) disable iff (RST)
        (CLK_EN && RESETS.full_reset) |=> (wdt_ctrl == wdr_pkg::WDT_CTRL_POR && pin_cfg == wdr_pkg::PIN_CFG_IO))
        else $error("Control words not reloaded");
endmodule : wdr_top

// >>> test/wdr_cpu_model.sv
// CPU core model issuing watchdog clear and halt instructions
`timescale 1ns/1ps
//////////////////////////////////////////
module wdr_cpu_model (
    input wire logic clk, // Low-speed clock
    input wire logic rst, // Power-on reset
    input wire logic [15:0] kick_gap, // Clear spacing, 0 stops
    input wire logic clr_req, // Extra clear
    input wire logic halt_req, // Halt request
    output logic clr_instr, // Clear pulse
    output logic halt_instr // Halt pulse
);
    logic [15:0] gap_cnt; // Cycles since last clear
    // Routine clears spaced by kick_gap
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_cnt <= 16'h0;
            clr_instr <= 1'b0;
            halt_instr <= 1'b0;
        end else begin
            gap_cnt <= (kick_gap != 16'h0 && gap_cnt < kick_gap) ? gap_cnt + 16'h1 : 16'h0;
            clr_instr <= clr_req | (kick_gap != 16'h0 && gap_cnt == kick_gap);
            halt_instr <= halt_req;
        end
    end
endmodule : wdr_cpu_model

// >>> test/wdr_top_test.sv
// Self-checking bench for the watchdog and reset control
`timescale 1ns/1ps
//////////////////////////////////////////
module wdr_top_test;
    localparam int SW_D = 4; // Software delay, same as the default
    localparam int REL_D = 20; // Release delay, longer than the default 16
    localparam logic [3:0] A_CTL = wdr_pkg::ADDR_WDT_CTRL, A_FLG = wdr_pkg::ADDR_RST_FLAGS; // Addresses
    localparam logic [3:0] A_PIN = wdr_pkg::ADDR_PIN_CFG, A_CMD = wdr_pkg::ADDR_CMD; // Addresses
    logic sys_clk = 1'b0, rst = 1'b1, low_power = 1'b0, ext_n = 1'b1; // Driven levels
    logic clr_req = 1'b0, halt_req = 1'b0, fr_seen; // Model requests
    logic [15:0] kick_gap = 16'd60; // Clear spacing
    logic clr_instr, halt_instr, pin_io_in, pin_is_reset; // Observed levels
    wdr_pkg::wdr_reset_t resets; // Reset outputs
    logic [3:0] awaddr = 4'h0, araddr = 4'h0; // Bus addresses
    logic [31:0] wdata = 32'h0, rdata, rd_data, seed = 32'hf0cf; // Data, random state
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0; // Master
    logic awready, wready, bvalid, arready, rvalid; // Slave
    logic [1:0] bresp, rresp, resp; // Responses
    int ctrl_m = 32'h53, pin_m = 32'h55, flags_m = 0; // Register model
    int bad_count = 0, tests_run = 0, n; // Tallies
    //////////////////////////////////////////
    wdr_top #(.SW_DELAY(SW_D), .REL_DELAY(REL_D)) dut_u (.SYS_CLK(sys_clk), .RST(rst), .CLK_EN(1'b1),
        .CLR_INSTR(clr_instr), .HALT_INSTR(halt_instr), .LOW_POWER(low_power), .EXT_RESET_N_IN(ext_n),
        .PIN_IO_IN(pin_io_in), .PIN_IS_RESET(pin_is_reset), .RESETS(resets), .S_AXI_AWADDR(awaddr),
        .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'h1),
        .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    wdr_cpu_model cpu_u (.clk(sys_clk), .rst(rst), .kick_gap(kick_gap), .clr_req(clr_req),
        .halt_req(halt_req), .clr_instr(clr_instr), .halt_instr(halt_instr));
    // 250 MHz clock
    always #2 sys_clk = ~sys_clk;
    // Flag effects of clear and halt
    always @(posedge sys_clk) begin
        if (clr_instr === 1'b1) flags_m &= ~32'h20;
        if (halt_instr === 1'b1) flags_m = (flags_m | 32'h20) & ~32'h10;
    end
    // Word compare
    task automatic check_reg(input string what, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check_reg
    // Level compare
    task automatic check_bit(input string what, input logic exp, input logic seen);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", what, exp, seen);
        end
    endtask : check_bit
    // Xorshift step
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : next_rand
    // Bus write, each channel held until taken
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        int k;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge sys_clk);
            if (awready === 1'b1 && awvalid) awvalid <= 1'b0;
            if (wready === 1'b1 && wvalid) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        resp = bresp;
        bready <= 1'b0;
        if (k == 64) check_bit("write_answer", 1'b1, 1'b0);
        @(posedge sys_clk);
    endtask : axi_wr
    // Bus read
    task automatic axi_rd(input logic [3:0] a);
        int k;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (k = 0; k < 64; k++) begin
            @(posedge sys_clk);
            if (arready === 1'b1 && arvalid) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        rd_data = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (k == 64) check_bit("read_answer", 1'b1, 1'b0);
        @(posedge sys_clk);
    endtask : axi_rd
    // Read against the model
    task automatic rd_chk(input string what, input logic [3:0] a, input int exp);
        axi_rd(a);
        check_reg(what, exp, rd_data);
    endtask : rd_chk
    // Edges until a reset output rises
    task automatic wait_evt(input int lim, input bit pcsp);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (n < lim && (pcsp ? resets.pc_sp_reset : resets.full_reset) !== 1'b1);
        fr_seen = resets.full_reset;
        repeat (3) @(posedge sys_clk);
    endtask : wait_evt
    // Full reset reloads both control words
    task automatic model_reload;
        ctrl_m = wdr_pkg::WDT_CTRL_POR;
        pin_m = wdr_pkg::PIN_CFG_IO;
    endtask : model_reload
    // Overflow after one clear or halt
    task automatic timeout_run(input int sel, input bit sleep);
        int per;
        per = 1 << ((sel < 4) ? 8 + 2 * sel : sel + 11);
        kick_gap <= 16'h0;
        axi_wr(A_CTL, {24'h0, wdr_pkg::KEY_ENABLE, sel[2:0]});
        ctrl_m = {wdr_pkg::KEY_ENABLE, sel[2:0]};
        low_power <= sleep;
        clr_req <= !sleep;
        halt_req <= sleep;
        @(posedge sys_clk);
        clr_req <= 1'b0;
        halt_req <= 1'b0;
        wait_evt(per + 16, sleep);
        check_bit("overflow_period", 1'b1, n >= per - 2 && n <= per + 4);
        check_bit("full_on_overflow", !sleep, fr_seen);
        flags_m |= 32'h10;
        if (!sleep) model_reload();
        low_power <= 1'b0;
        rd_chk("flags_overflow", A_FLG, flags_m);
        rd_chk("ctrl_overflow", A_CTL, ctrl_m);
    endtask : timeout_run
    // Verdict and end of run
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    // Hang guard
    initial begin
        #320000;
        check_bit("run_time", 1'b1, 1'b0);
        finish_test();
    end
    //////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        check_reg("resets_por", 32'hf, {28'h0, resets});
        rst <= 1'b0;
        repeat (REL_D + 4) @(posedge sys_clk);
        check_reg("resets_run", 32'h0, {28'h0, resets});
        rd_chk("ctrl_por", A_CTL, ctrl_m);
        rd_chk("pin_por", A_PIN, pin_m);
        rd_chk("flags_por", A_FLG, flags_m);
        rd_chk("cmd_read", A_CMD, 0);
        axi_rd(4'h2); // Byte address inside the control word
        check_reg("alias_rd_resp", wdr_pkg::RESP_OKAY, {30'h0, resp});
        check_reg("alias_rd_data", ctrl_m, rd_data);
        axi_wr(4'h2, {24'h0, wdr_pkg::KEY_DISABLE, 3'h7});
        ctrl_m = {wdr_pkg::KEY_DISABLE, 3'h7};
        check_reg("alias_wr_resp", wdr_pkg::RESP_OKAY, {30'h0, resp});
        rd_chk("alias_wr_ctrl", A_CTL, ctrl_m);
        axi_wr(A_CTL, {24'h0, wdr_pkg::KEY_DISABLE, 3'h0});
        check_reg("write_resp", wdr_pkg::RESP_OKAY, {30'h0, resp});
        kick_gap <= 16'h0;
        wait_evt(600, 1'b1);
        check_bit("disabled_quiet", 1'b1, n == 600);
        for (int s = 0; s < 5; s++) timeout_run(s, 1'b0);
        timeout_run(0, 1'b1);
        kick_gap <= 16'd60;
        for (int i = 0; i < 2; i++) begin
            axi_wr(i ? A_PIN : A_CTL, i ? 32'h33 : 32'h0);
            wait_evt(40, 1'b0);
            check_bit("fault_delay", 1'b1, n >= SW_D - 2 && n <= SW_D + 2);
            flags_m |= i ? 32'h8 : 32'h1;
            model_reload();
            rd_chk("flags_fault", A_FLG, flags_m);
            rd_chk("ctrl_fault", A_CTL, ctrl_m);
            rd_chk("pin_fault", A_PIN, pin_m);
        end
        for (int i = 0; i < 4; i++) begin
            seed = next_rand(seed);
            axi_wr(A_FLG, i == 3 ? 32'h0 : seed);
            flags_m = flags_m & (i == 3 ? 0 : {24'h0, seed[7:0]});
            rd_chk("flags_write", A_FLG, flags_m);
        end
        kick_gap <= 16'h0;
        axi_wr(A_CMD, 32'h2);
        flags_m = (flags_m | 32'h20) & ~32'h10;
        rd_chk("flags_halt_cmd", A_FLG, flags_m);
        axi_wr(A_CMD, 32'h1);
        flags_m &= ~32'h20;
        rd_chk("flags_clear_cmd", A_FLG, flags_m);
        ext_n <= 1'b0;
        wait_evt(20, 1'b1);
        check_bit("pin_as_io", 1'b1, n == 20);
        check_bit("pin_io_level", 1'b0, pin_io_in);
        ext_n <= 1'b1;
        axi_wr(A_PIN, 32'haa);
        pin_m = 32'haa;
        check_bit("pin_is_reset", 1'b1, pin_is_reset);
        rd_chk("pin_reset_mode", A_PIN, pin_m);
        ext_n <= 1'b0;
        wait_evt(8, 1'b1);
        check_bit("pin_low_reset", 1'b1, n < 8 && fr_seen);
        model_reload();
        ext_n <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (resets.inhibit === 1'b1 && n < 100);
        check_bit("release_delay", 1'b1, n >= REL_D - 6 && n <= REL_D + 6);
        rd_chk("pin_after_pin_reset", A_PIN, pin_m);
        finish_test();
    end
endmodule : wdr_top_test
